// file: verilog/sam_core.sv
// Purpose: register front end and acknowledge frame-pending decision for
//          the source address matching table
// Assumes: the command decoder issues one-cycle wr or rd strobes on the
//          device register port, on the same clock; lookup requests come
//          from receive logic on the same clock
// Notes:   read data and lookup answers appear one cycle after the strobe;
//          a control write that sets both strobes invalidates the entry;
//          the index written together with a strobe is the one it acts on;
//          a lookup in the cycle of a table write sees the old contents
`timescale 1ns/1ps
module sam_core
	import sam_pkg::*;
(
	input  wire logic                          clk_i,
	input  wire logic                          resetn_i,
	input  wire sam_pkg::sam_reg_req_type      reg_req_i,
	output sam_pkg::sam_reg_resp_type          reg_resp_o,
	input  wire sam_pkg::sam_lookup_req_type   lookup_req_i,
	output sam_pkg::sam_lookup_resp_type       lookup_resp_o,
	output logic                               match_enable_o
);
	import sam_pkg::*;

	// control register storage
	logic [IDX_W-1:0]   index_r;
	logic [IDX_W-1:0]   index_nxt;
	logic               pending_default_bit_r;
	logic               pending_default_bit_nxt;
	logic               match_enable_r;
	logic               match_enable_nxt;

	// answer registers
	logic               rvalid_r;
	logic [DATA_W-1:0]  rdata_r;
	logic [DATA_W-1:0]  rdata_nxt;
	logic               lk_done_r;
	logic               lk_pending_r;
	logic               lk_pending_nxt;

	// address decode
	wire                sel_control;
	wire                sel_low;
	wire                sel_high;
	wire                wr_control;
	wire                wr_low;
	wire                wr_high;
	wire                strobe_activate;
	wire                strobe_invalidate;
	wire [SUM_W-1:0]    entry_sum;
	wire                table_hit;
	wire [DATA_W-1:0]   control_view;
	wire [DATA_W-1:0]   sum_low_view;
	wire [DATA_W-1:0]   sum_high_view;
	wire [IDX_W-1:0]    wr_index;
	wire                wr_pend;
	wire                wr_enable;

	// offset compare shared by the three register selects
	function automatic logic at_offset(
		input logic [ADDR_W-1:0] addr,
		input logic [ADDR_W-1:0] ofs
	);
		return (addr == ofs);
	endfunction

	// a strobe fires only in a control write that carries its bit
	function automatic logic ctl_strobe(
		input logic              wr_ctl,
		input logic [DATA_W-1:0] wdata,
		input int unsigned       pos
	);
		return wr_ctl && wdata[pos];
	endfunction

	// control image as software reads it; the strobes never read back
	function automatic logic [DATA_W-1:0] control_image(
		input logic [IDX_W-1:0] idx,
		input logic             pend,
		input logic             enable
	);
		logic [DATA_W-1:0] img;
		img = RST_RDATA;
		img[CTL_INDEX_HI:CTL_INDEX_LO] = idx;
		img[CTL_PEND_BIT] = pend;
		img[CTL_EN_BIT] = enable;
		img[CTL_ACT_BIT] = 1'b0;
		img[CTL_INV_BIT] = 1'b0;
		return img;
	endfunction

	// one byte of a checksum; the upper half answers the high offset
	function automatic logic [DATA_W-1:0] sum_byte(
		input logic [SUM_W-1:0] word,
		input logic             upper
	);
		return upper ? word[SUM_W-1:DATA_W] : word[DATA_W-1:0];
	endfunction

	// frame-pending choice for the acknowledge builder; with matching on,
	// the software default is ignored even when no entry is valid
	function automatic logic ack_pending(
		input logic enable,
		input logic hit,
		input logic pend
	);
		return enable ? hit : pend;
	endfunction

	// register selects and write qualifiers
	assign sel_control = at_offset(reg_req_i.addr, OFS_CONTROL);
	assign sel_low     = at_offset(reg_req_i.addr, OFS_SUM_LOW);
	assign sel_high    = at_offset(reg_req_i.addr, OFS_SUM_HIGH);
	assign wr_control  = reg_req_i.wr && sel_control;
	assign wr_low      = reg_req_i.wr && sel_low;
	assign wr_high     = reg_req_i.wr && sel_high;

	// strobes act only in the write cycle; nothing is stored for them
	assign strobe_activate = ctl_strobe(wr_control, reg_req_i.wdata,
		CTL_ACT_BIT);
	assign strobe_invalidate = ctl_strobe(wr_control, reg_req_i.wdata,
		CTL_INV_BIT);

	// fields of the control byte being written
	assign wr_index  = reg_req_i.wdata[CTL_INDEX_HI:CTL_INDEX_LO];
	assign wr_pend   = reg_req_i.wdata[CTL_PEND_BIT];
	assign wr_enable = reg_req_i.wdata[CTL_EN_BIT];

	// the index taking effect in the same write as a strobe is the new one,
	// so software may select and activate with a single write
	assign index_nxt = wr_control ? wr_index : index_r;
	assign pending_default_bit_nxt = wr_control ?
		wr_pend : pending_default_bit_r;
	assign match_enable_nxt = wr_control ?
		wr_enable : match_enable_r;

	// strobe bits always read back as zero
	assign control_view = control_image(index_r, pending_default_bit_r,
		match_enable_r);

	// both checksum bytes of the entry under the current index
	assign sum_low_view  = sum_byte(entry_sum, 1'b0);
	assign sum_high_view = sum_byte(entry_sum, 1'b1);

	// read mux; unmapped offsets answer zero
	assign rdata_nxt = sel_control ? control_view :
		sel_low  ? sum_low_view :
		sel_high ? sum_high_view : RST_RDATA;

	// ack pending source: default bit or lookup result
	assign lk_pending_nxt = ack_pending(match_enable_r, table_hit,
		pending_default_bit_r);

	// table of checksums and valid flags
	sam_table u_table (
		.clk_i       (clk_i),
		.resetn_i    (resetn_i),
		.index_i     (index_nxt),
		.wr_low_i    (wr_low),
		.wr_high_i   (wr_high),
		.wdata_i     (reg_req_i.wdata),
		.set_valid_i (strobe_activate),
		.clr_valid_i (strobe_invalidate),
		.probe_sum_i (lookup_req_i.checksum),
		.entry_sum_o (entry_sum),
		.hit_o       (table_hit)
	);

	// control register; strobes never latch
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			index_r               <= RST_INDEX;
			pending_default_bit_r <= RST_PEND;
			match_enable_r        <= RST_EN;
		end else begin
			index_r               <= index_nxt;
			pending_default_bit_r <= pending_default_bit_nxt;
			match_enable_r        <= match_enable_nxt;
		end
	end

	// read answer, one cycle after the read strobe
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			rvalid_r <= 1'b0;
			rdata_r  <= RST_RDATA;
		end else begin
			rvalid_r <= reg_req_i.rd;
			if (reg_req_i.rd) begin
				rdata_r <= rdata_nxt;
			end
		end
	end

	// lookup pending held until the next request; done pulses for one cycle
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			lk_done_r    <= 1'b0;
			lk_pending_r <= 1'b0;
		end else begin
			lk_done_r <= lookup_req_i.valid;
			if (lookup_req_i.valid) begin
				lk_pending_r <= lk_pending_nxt;
			end
		end
	end

	// port images of the answer registers
	assign reg_resp_o.valid      = rvalid_r;
	assign reg_resp_o.data       = rdata_r;
	assign lookup_resp_o.done    = lk_done_r;
	assign lookup_resp_o.pending = lk_pending_r;
	assign match_enable_o        = match_enable_r;

endmodule

// file: verilog/sam_pkg.sv
// Purpose: shared constants and carrier types for the source address
//          matching table block
// Assumes: byte-wide register port driven by the serial command decoder
// Notes:   offsets are byte addresses on the device register port
package sam_pkg;

	// register port geometry
	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 8;
	localparam int unsigned SUM_W = 16;
	localparam int unsigned IDX_W = 4;
	localparam int unsigned ENTRIES = 16;

	// register offsets
	localparam logic [7:0] OFS_CONTROL = 8'h08;
	localparam logic [7:0] OFS_SUM_LOW = 8'h09;
	localparam logic [7:0] OFS_SUM_HIGH = 8'h0a;

	// control register field positions
	localparam int unsigned CTL_INDEX_HI = 7;
	localparam int unsigned CTL_INDEX_LO = 4;
	localparam int unsigned CTL_PEND_BIT = 3;
	localparam int unsigned CTL_EN_BIT = 2;
	localparam int unsigned CTL_ACT_BIT = 1;
	localparam int unsigned CTL_INV_BIT = 0;

	// reset values
	localparam logic [3:0] RST_INDEX = 4'h0;
	localparam logic RST_PEND = 1'b0;
	localparam logic RST_EN = 1'b0;
	localparam logic [15:0] RST_SUM = 16'h0000;
	localparam logic [7:0] RST_RDATA = 8'h00;

	// one register access from the command decoder
	typedef struct packed {
		logic                    wr;
		logic                    rd;
		logic [ADDR_W-1:0]       addr;
		logic [DATA_W-1:0]       wdata;
	} sam_reg_req_type;

	// register read answer
	typedef struct packed {
		logic                    valid;
		logic [DATA_W-1:0]       data;
	} sam_reg_resp_type;

	// lookup request from the receive path
	typedef struct packed {
		logic                    valid;
		logic [SUM_W-1:0]        checksum;
	} sam_lookup_req_type;

	// lookup answer to the acknowledge builder
	typedef struct packed {
		logic                    done;
		logic                    pending;
	} sam_lookup_resp_type;

endpackage

// file: verilog/sam_table.sv
// Purpose: sixteen-entry checksum table with valid flags and a parallel
//          match against all valid entries
// Assumes: single clock, synchronous active-low reset
// Notes:   byte writes go straight into the selected entry, so the two
//          halves may arrive in either order
`timescale 1ns/1ps
module sam_table
	import sam_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   resetn_i,
	input  wire logic [sam_pkg::IDX_W-1:0] index_i,
	input  wire logic                   wr_low_i,
	input  wire logic                   wr_high_i,
	input  wire logic [sam_pkg::DATA_W-1:0] wdata_i,
	input  wire logic                   set_valid_i,
	input  wire logic                   clr_valid_i,
	input  wire logic [sam_pkg::SUM_W-1:0] probe_sum_i,
	output logic      [sam_pkg::SUM_W-1:0] entry_sum_o,
	output logic                        hit_o
);
	import sam_pkg::*;

	logic [SUM_W-1:0] entry_checksum_r [ENTRIES];
	logic [ENTRIES-1:0] valid_r;
	logic [ENTRIES-1:0] match_vec;

	// read port follows the current index, not the last write
	assign entry_sum_o = entry_checksum_r[index_i];

	// compare every entry at once; invalid entries never match
	always_comb begin
		for (int i = 0; i < ENTRIES; i++) begin
			match_vec[i] = valid_r[i] &&
				(entry_checksum_r[i] == probe_sum_i);
		end
	end

	assign hit_o = |match_vec;

	// checksum storage, byte at a time
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			for (int i = 0; i < ENTRIES; i++) begin
				entry_checksum_r[i] <= RST_SUM;
			end
		end else begin
			if (wr_low_i) begin
				entry_checksum_r[index_i][7:0] <= wdata_i;
			end
			if (wr_high_i) begin
				entry_checksum_r[index_i][15:8] <= wdata_i;
			end
		end
	end

	// valid flags; invalidate beats activate if both are written at once
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			valid_r <= '0;
		end else if (clr_valid_i) begin
			valid_r[index_i] <= 1'b0;
		end else if (set_valid_i) begin
			valid_r[index_i] <= 1'b1;
		end
	end

endmodule

// file: tb/sam_core_assertions.sv
// Purpose: port checks for sam_core
// Assumes: one clock, synchronous active-low reset
// Notes:   pend_r shadows the default bit, which has no port
`timescale 1ns/1ps
module sam_core_chk
	import sam_pkg::*;
(
	input wire logic                         clk_i,
	input wire logic                         resetn_i,
	input wire sam_pkg::sam_reg_req_type     reg_req_i,
	input wire sam_pkg::sam_reg_resp_type    reg_resp_o,
	input wire sam_pkg::sam_lookup_req_type  lookup_req_i,
	input wire sam_pkg::sam_lookup_resp_type lookup_resp_o,
	input wire logic                         match_enable_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!resetn_i);
	logic pend_r;
	wire  cw = reg_req_i.wr && reg_req_i.addr == OFS_CONTROL;
	wire  cr = reg_req_i.rd && reg_req_i.addr == OFS_CONTROL;
	wire  lv = lookup_req_i.valid;
	// default bit tracked from control writes
	always_ff @(posedge clk_i) begin
		if (!resetn_i) pend_r <= 1'b0;
		else if (cw) pend_r <= reg_req_i.wdata[CTL_PEND_BIT];
	end
	a_read_answer: assert property (
		reg_req_i.rd |=> reg_resp_o.valid) else $error("read not answered");
	a_no_stray: assert property (
		!reg_req_i.rd |=> !reg_resp_o.valid) else $error("stray answer");
	a_strobes_zero: assert property (
		cr |=> reg_resp_o.data[1:0] == 2'h0) else $error("strobe reads one");
	a_enable_follows: assert property (
		cw |=> match_enable_o == $past(reg_req_i.wdata[CTL_EN_BIT]))
		else $error("enable not written");
	a_enable_holds: assert property (
		!cw |=> $stable(match_enable_o)) else $error("enable moved");
	a_lookup_done: assert property (
		lv |=> lookup_resp_o.done) else $error("lookup not answered");
	a_lookup_quiet: assert property (
		!lv |=> !lookup_resp_o.done && $stable(lookup_resp_o.pending))
		else $error("lookup answer moved");
	a_default_pend: assert property (
		lv && !match_enable_o |=> lookup_resp_o.pending == $past(pend_r))
		else $error("default bit not used");
	a_reset_clears: assert property (disable iff (1'b0)
		!resetn_i |=> !reg_resp_o.valid && !lookup_resp_o.done
		&& !match_enable_o) else $error("reset left outputs set");
endmodule
bind sam_core sam_core_chk i_sam_core_chk (.clk_i(clk_i),
	.resetn_i(resetn_i), .reg_req_i(reg_req_i), .reg_resp_o(reg_resp_o),
	.lookup_req_i(lookup_req_i), .lookup_resp_o(lookup_resp_o),
	.match_enable_o(match_enable_o));

// file: tb/sam_host.sv
// Purpose: host model on the register port
// Assumes: one access at a time, on the bench clock
// Notes:   idle address and data lines show the inverse of the last value; wr and rd idle low
`timescale 1ns/1ps
module sam_host
	import sam_pkg::*;
(
	input  wire logic                      clk_i,
	output sam_pkg::sam_reg_req_type       reg_req_o,
	input  wire sam_pkg::sam_reg_resp_type reg_resp_i
);
	initial reg_req_o = '0;
	// one-cycle strobe; scrambled idle so stale values cannot pass
	task automatic access(input logic w, input logic [7:0] a, d);
		@(posedge clk_i);
		reg_req_o <= '{w, !w, a, d};
		@(posedge clk_i);
		reg_req_o <= '{1'b0, 1'b0, ~a, ~d};
	endtask
	// answer stands one cycle after the strobe edge
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		access(1'b0, a, 8'h00);
		#1 d = reg_resp_i.valid ? reg_resp_i.data : 8'hxx;
	endtask
endmodule

// file: tb/tb_sam_core.sv
// Purpose: self-checking bench for sam_core
// Assumes: host model drives the register port
// Notes:   lookups are driven by the bench itself
`timescale 1ns/1ps
module tb_sam_core;
	import sam_pkg::*;
	logic                clk_i = 1'b0;
	logic                resetn_i = 1'b0;
	sam_reg_req_type     reg_req;
	sam_reg_resp_type    reg_resp;
	sam_lookup_req_type  lq = '0;
	sam_lookup_resp_type lr;
	logic                match_en;
	logic [7:0]          d;
	int                  num_errors = 0;
	int                  tests_run = 0;
	int                  cycles = 0;
	// write then read back: {addr, wdata, expected}
	logic [23:0] rows [5] = '{24'h08_36_34, 24'h08_99_98,
		24'h09_ab_ab, 24'h0a_cd_cd, 24'h0b_55_00};

	sam_core i_sam_core (.clk_i(clk_i), .resetn_i(resetn_i),
		.reg_req_i(reg_req), .reg_resp_o(reg_resp), .lookup_req_i(lq),
		.lookup_resp_o(lr), .match_enable_o(match_en));
	sam_host i_sam_host (.clk_i(clk_i), .reg_req_o(reg_req),
		.reg_resp_i(reg_resp));

	initial begin
		forever #12.5 clk_i = ~clk_i;
	end
	// hang guard, far above the fewer than a hundred cycles needed
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic chk(input logic [7:0] got, exp);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, v);
		i_sam_host.access(1'b1, a, v);
	endtask
	task automatic rb(input logic [7:0] a, exp);
		i_sam_host.rd(a, d);
		chk(d, exp);
	endtask
	// lookup pulse, then done and pending one cycle later
	task automatic lk(input logic [15:0] s, input logic exp);
		@(posedge clk_i);
		lq <= '{1'b1, s};
		@(posedge clk_i);
		lq <= '{1'b0, ~s};
		#1 chk({6'h00, lr.done, lr.pending}, {7'h01, exp});
	endtask
	task summarize;
		if (num_errors == 0 && tests_run > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	initial begin
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		rb(OFS_CONTROL, 8'h00);
		rb(OFS_SUM_LOW, 8'h00);
		rb(OFS_SUM_HIGH, 8'h00);
		wr(OFS_CONTROL, 8'h04);
		#1 chk({7'h00, match_en}, 8'h01);
		lk(16'h0000, 1'b0);
		foreach (rows[i]) begin
			wr(rows[i][23:16], rows[i][15:8]);
			rb(rows[i][23:16], rows[i][7:0]);
		end
		chk({7'h00, match_en}, 8'h00);
		lk(16'hcdab, 1'b1);
		wr(OFS_CONTROL, 8'h96);
		lk(16'hcdab, 1'b1);
		lk(16'h1234, 1'b0);
		wr(OFS_CONTROL, 8'h9c);
		lk(16'h1234, 1'b0);
		lk(16'h0000, 1'b1);
		wr(OFS_CONTROL, 8'h50);
		wr(OFS_SUM_HIGH, 8'h12);
		wr(OFS_SUM_LOW, 8'h34);
		rb(OFS_SUM_LOW, 8'h34);
		rb(OFS_SUM_HIGH, 8'h12);
		wr(OFS_CONTROL, 8'h90);
		rb(OFS_SUM_LOW, 8'hab);
		wr(OFS_CONTROL, 8'h95);
		lk(16'hcdab, 1'b0);
		lk(16'h0000, 1'b1);
		// mid-run reset: answers, control and the whole table clear again
		@(posedge clk_i);
		resetn_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		#1 chk({4'h0, lr, reg_resp.valid, match_en}, 8'h00);
		chk(reg_resp.data, 8'h00);
		@(posedge clk_i);
		resetn_i <= 1'b1;
		rb(OFS_CONTROL, 8'h00);
		wr(OFS_CONTROL, 8'h54);
		rb(OFS_SUM_LOW, 8'h00);
		rb(OFS_SUM_HIGH, 8'h00);
		lk(16'h0000, 1'b0);
		lk(16'h1234, 1'b0);
		summarize();
	end
endmodule
